/* core/cpwm_three_phase.sv */
// complementary three-phase pwm with dead time, adc triggers and cutoff
//
// Behaviour
// - compare match of a channel counter with its compare raises a request
// - secondary counter underflow while counting down raises a request
// - clock pin is general input or external count clock, never pwm output
// - phase one drives normal and complementary waveforms as a pair
// - phase one counter output is complement of normal, minus dead time
// - phase two drives normal and counter outputs
// - phase three drives normal and counter outputs
// - toggle output inverts at every half pwm period while counting
// - cutoff input forces outputs to initial levels; pin also readable in the status register
// - reading a channel counter returns its current count
// - writing a channel counter loads that value
// - normal and counter outputs have separate active and initial levels
// - buffered compare transfer timing is selectable
// - pwm period stays fixed once counting starts
// - adc trigger on period match and on secondary underflow
// - any channel compare match may trigger the adc
// - trigger enable, select and trigger control register choose adc events
// - adc events may go via the event link output instead
// - secondary underflow turns both counters up; period match turns down
// - period is twice (m plus 2 minus p); p is preloaded primary count
// - normal width 2(m-n-p+1), counter width 2(n+1-p)
// - clearing both run bits with stop select set stops, outputs initial
`timescale 1ns/10ps
`default_nettype none
`include "cpwm_params.svh"

module cpwm_three_phase #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [5:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // pins
  input wire logic clk_pin_i,
  input wire logic cutoff_pin_i,
  output logic [2:0] normal_o,
  output logic [2:0] counter_o,
  output logic toggle_o,
  // events
  output logic [3:0] match_irq_o,
  output logic underflow_irq_o,
  output logic adc_trig_o,
  output logic elc_event_o,
  output cpwm_pkg::cnt_state_t state_o
);
  import cpwm_pkg::*;

  // refuse widths the 16-bit register port cannot carry
  generate
    if (WIDTH < 4 || WIDTH > 16) begin : g_bad_width
      $error("WIDTH must lie in 4..16");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [15:0] ctrl_q, func_q, adcc_q;
  logic [WIDTH-1:0] per_buf_q, per_q, dead_q;
  logic [WIDTH-1:0] prim_q, sec_q;
  logic [WIDTH-1:0] buf_q [3];
  logic [WIDTH-1:0] cmp_q [3];
  logic cutoff_q, clk_pin_q, hold_q, toggle_q;
  logic [15:0] rdata_q;
  cnt_state_t state_q;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction

  wire we_ctrl = wr_i && hit(addr_i, `OFS_CTRL);
  wire we_prim = wr_i && hit(addr_i, `OFS_PRIM);
  wire we_sec = wr_i && hit(addr_i, `OFS_SEC);
  wire we_per = wr_i && hit(addr_i, `OFS_PER);
  wire we_stat = wr_i && hit(addr_i, `OFS_STAT);
  wire [WIDTH-1:0] wval = wdata_i[WIDTH-1:0];
  wire [WIDTH-1:0] ones = '1;

  // stop only when both run bits cleared and stop select set
  wire stop_req = we_ctrl && ctrl_q[`B_STOPSEL] && !wdata_i[`B_RUN0] && !wdata_i[`B_RUN1];
  // while stop select is clear, only a write setting both run bits changes them
  wire [1:0] run_d = (we_ctrl && (ctrl_q[`B_STOPSEL] || wdata_i[1:0] == 2'h3)) ?
                     wdata_i[1:0] : ctrl_q[1:0];
  wire [15:0] ctrl_d = we_ctrl ? {wdata_i[15:2], run_d} : ctrl_q;
  wire running = (state_q != ST_STOP);
  wire start = !running && (ctrl_d[1:0] == 2'h3);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `CTRL_RST;
      func_q <= `FUNC_RST;
      adcc_q <= `ADCC_RST;
      per_buf_q <= WIDTH'(`PER_RST);
    end else begin
      ctrl_q <= stop_req ? {ctrl_d[15:2], 2'h0} : ctrl_d;
      if (wr_i && hit(addr_i, `OFS_FUNC)) func_q <= wdata_i;
      if (wr_i && hit(addr_i, `OFS_ADCC)) adcc_q <= wdata_i;
      if (we_per) per_buf_q <= wval;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_buf
      wire we_buf = wr_i && hit(addr_i, 6'(`OFS_PH1 + 4 * g));
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          buf_q[g] <= '0;
        end else if (we_buf) begin
          buf_q[g] <= wval;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // count engine
  // external clock pin edge
  wire tick = ctrl_q[`B_EXTCLK] ? (clk_pin_i && !clk_pin_q) : 1'b1;
  wire at_top = (state_q == ST_UP) && !hold_q && (prim_q == per_q);
  wire at_bot = (state_q == ST_DOWN) && (sec_q == '0);
  wire top_ev = tick && at_top;
  wire bot_ev = tick && at_bot;
  cnt_state_t state_d;
  logic [WIDTH-1:0] prim_d, sec_d;
  logic hold_d;

  // turn points, one hold tick at each end
  // the hold ticks give twice (m+2-p)
  always_comb begin
    state_d = state_q;
    prim_d = prim_q;
    sec_d = sec_q;
    hold_d = hold_q;
    if (start) begin
      state_d = ST_UP;
      sec_d = '0;
      hold_d = 1'b0;
    end else if (stop_req) begin
      state_d = ST_STOP;
    end else if (running && tick) begin
      if (state_q == ST_UP) begin
        if (hold_q) begin
          hold_d = 1'b0;
        end else if (at_top) begin
          state_d = ST_DOWN;
        end else begin
          prim_d = prim_q + 1'b1;
          sec_d = sec_q + 1'b1;
        end
      end else begin
        prim_d = prim_q - 1'b1;
        sec_d = sec_q - 1'b1;
        if (at_bot) begin
          state_d = ST_UP;
          hold_d = 1'b1;
        end
      end
    end
    if (we_prim) prim_d = wval;
    if (we_sec) sec_d = wval;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_STOP;
      prim_q <= '0;
      sec_q <= '0;
      hold_q <= 1'b0;
      clk_pin_q <= 1'b0;
    end else begin
      state_q <= state_d;
      prim_q <= prim_d;
      sec_q <= sec_d;
      hold_q <= hold_d;
      clk_pin_q <= clk_pin_i;
    end
  end

  // period and dead time captured once at start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_q <= WIDTH'(`PER_RST);
      dead_q <= '0;
    end else if (start) begin
      per_q <= per_buf_q;
      dead_q <= prim_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare transfer and phase outputs
  wire [1:0] xfer_sel = ctrl_q[`B_XFER+1:`B_XFER];
  wire xfer = !running || xfer_sel == `XFER_NOW ||
              (xfer_sel[0] && top_ev) || (xfer_sel[1] && bot_ev);
  // cutoff sticky until cleared with pin released; set wins
  wire cut_set = ctrl_q[`B_CUTEN] && cutoff_pin_i;
  wire cut_clr = we_stat && wdata_i[`B_CUTCLR];
  wire forced = !running || cutoff_q;
  wire [2:0] m_ph;
  wire [2:0] nrm_raw, cnt_raw, nrm_pin, cnt_pin;

  generate
    for (g = 0; g < 3; g++) begin : g_ph
      wire [WIDTH:0] thr = {1'b0, cmp_q[g]} + {1'b0, dead_q};
      // phase one on primary, phases two and three on secondary
      assign m_ph[g] = tick && running &&
                       ((g == 0) ? (prim_q == cmp_q[g]) : (sec_q == cmp_q[g]));
      // widths set by n+p and n thresholds
      assign nrm_raw[g] = ({1'b0, prim_q} >= thr);
      // counter side gated by normal side
      assign cnt_raw[g] = (prim_q < cmp_q[g]) && !nrm_raw[g];
      assign nrm_pin[g] = forced ? ctrl_q[`B_NINIT] : (nrm_raw[g] ~^ ctrl_q[`B_NACT]);
      assign cnt_pin[g] = forced ? ctrl_q[`B_CINIT] : (cnt_raw[g] ~^ ctrl_q[`B_CACT]);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cmp_q[g] <= '0;
        end else if (xfer) begin
          cmp_q[g] <= buf_q[g];
        end
      end
    end
  endgenerate

  // forced to initial levels once stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      normal_o <= 3'h0;
      counter_o <= 3'h0;
      cutoff_q <= 1'b0;
    end else begin
      normal_o <= nrm_pin;
      counter_o <= cnt_pin;
      cutoff_q <= cut_set || (cutoff_q && !cut_clr);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      toggle_q <= 1'b0;
    end else if (top_ev || bot_ev) begin
      toggle_q <= !toggle_q;
    end
  end
  assign toggle_o = toggle_q;

  ////////////////////////////////////////////////////////////////////////
  // events and adc triggers
  // match requests: period, phase one..three
  wire [3:0] match_d = {m_ph[2], m_ph[1], m_ph[0], top_ev};
  wire base_ev = (adcc_q[`B_ADBOTH] || !func_q[`B_ADSEL]) && top_ev ||
                 (adcc_q[`B_ADBOTH] || func_q[`B_ADSEL]) && bot_ev;
  wire trig = func_q[`B_ADEN] && (base_ev || |(adcc_q[2:0] & m_ph));

  // routed via event link or direct
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      match_irq_o <= 4'h0;
      underflow_irq_o <= 1'b0;
      adc_trig_o <= 1'b0;
      elc_event_o <= 1'b0;
    end else begin
      match_irq_o <= match_d;
      underflow_irq_o <= bot_ev;
      adc_trig_o <= trig && !func_q[`B_ELC];
      elc_event_o <= trig && func_q[`B_ELC];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path
  wire [15:0] stat = {11'h0, clk_pin_i, cutoff_pin_i, state_q == ST_DOWN, running, cutoff_q};
  logic [15:0] rd_mux;
  always_comb begin
    case (addr_i)
      `OFS_CTRL: rd_mux = ctrl_q;
      `OFS_FUNC: rd_mux = func_q;
      `OFS_ADCC: rd_mux = adcc_q;
      `OFS_PRIM: rd_mux = 16'(prim_q);
      `OFS_SEC: rd_mux = 16'(sec_q);
      `OFS_PER: rd_mux = 16'(per_buf_q);
      `OFS_PH1: rd_mux = 16'(buf_q[0]);
      `OFS_PH2: rd_mux = 16'(buf_q[1]);
      `OFS_PH3: rd_mux = 16'(buf_q[2]);
      `OFS_STAT: rd_mux = stat;
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rd_i ? rd_mux : 16'h0000;
    end
  end
  assign rdata_o = rdata_q;
  assign state_o = state_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_match_request: assert property (top_ev |=> match_irq_o[0])
    else $error("period match without request");
  a_underflow_request: assert property (bot_ev |=> underflow_irq_o)
    else $error("underflow without request");
  a_phase_exclusive: assert property (!(nrm_raw[0] && cnt_raw[0]))
    else $error("phase one both active");
  a_period_fixed: assert property (running && !start |=> $stable(per_q))
    else $error("period moved while counting");
  a_toggle_turn: assert property (top_ev |=> toggle_o != $past(toggle_o))
    else $error("toggle missed a half period");
  a_bottom_turn: assert property (bot_ev && !we_prim |=> state_q == ST_UP ##1
    (state_q == ST_UP))
    else $error("underflow did not turn up");
  a_stop_levels: assert property (stop_req |=> ##1 normal_o == {3{$past(ctrl_q[`B_NINIT])}})
    else $error("outputs not at initial level");
  a_counter_write: assert property (we_prim |=> prim_q == $past(wval))
    else $error("counter write lost");
  a_read_data: assert property (rd_i && addr_i == `OFS_SEC |=>
    rdata_o == 16'($past(sec_q)))
    else $error("counter read wrong");

  c_top: cover property (top_ev);
  c_bottom: cover property (bot_ev);
  c_adc: cover property (adc_trig_o);
  c_cutoff: cover property (cutoff_q && running);

endmodule // cpwm_three_phase
`default_nettype wire

/* core/cpwm_params.svh */
// register map, field positions and reset values of the three-phase pwm
`ifndef CPWM_PARAMS_SVH
`define CPWM_PARAMS_SVH
`define OFS_CTRL 6'h00
`define OFS_FUNC 6'h04
`define OFS_ADCC 6'h08
`define OFS_PRIM 6'h0c
`define OFS_SEC 6'h10
`define OFS_PER 6'h14
`define OFS_PH1 6'h18
`define OFS_PH2 6'h1c
`define OFS_PH3 6'h20
`define OFS_STAT 6'h24
`define B_RUN0 0
`define B_RUN1 1
`define B_STOPSEL 2
`define B_NINIT 3
`define B_CINIT 4
`define B_NACT 5
`define B_CACT 6
`define B_EXTCLK 7
`define B_CUTEN 8
`define B_XFER 9
`define B_ADEN 0
`define B_ADSEL 1
`define B_ELC 2
`define B_ADBOTH 3
`define B_CUTCLR 0
`define CTRL_RST 16'h0060
`define FUNC_RST 16'h0000
`define ADCC_RST 16'h0000
`define PER_RST 16'hffff
`define XFER_NOW 2'h0
`define XFER_TOP 2'h1
`define XFER_BOT 2'h2
`endif

/* core/cpwm_pkg.sv */
// types shared by the three-phase pwm
package cpwm_pkg;
  typedef enum logic [1:0] {
    ST_STOP,
    ST_UP,
    ST_DOWN
  } cnt_state_t;
endpackage

/* testbench/gate_adc_model.sv */
// gate driver and converter model watching the pwm pins
`timescale 1ns/10ps
`default_nettype none

module gate_adc_model (
  // clock
  input wire logic clk_i,
  // gate inputs, active high as the bench configures them
  input wire logic [2:0] normal_i,
  input wire logic [2:0] counter_i,
  // conversion start
  input wire logic adc_trig_i,
  // observed counts
  output var int overlap_o,
  output var int conv_o
);
  int n_ov = 0;
  int n_cv = 0;
  assign overlap_o = n_ov;
  assign conv_o = n_cv;
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if ((normal_i & counter_i) != 3'h0) begin
      n_ov <= n_ov + 1;
    end
    if (adc_trig_i === 1'b1) begin
      n_cv <= n_cv + 1;
    end
  end
endmodule // gate_adc_model
`default_nettype wire

/* testbench/complementary_three_phase_pwm_bench.sv */
// self-checking bench for the complementary three-phase pwm
`timescale 1ns/10ps
`default_nettype none
`include "cpwm_params.svh"

module complementary_three_phase_pwm_bench;
  import cpwm_pkg::*;
  typedef struct {logic [5:0] a; logic w; logic [15:0] d; logic [15:0] e;} row_t;
  logic clk_i, rst_i, wr_i, rd_i, clk_pin_i, cutoff_pin_i, toggle_o, underflow_irq_o;
  logic adc_trig_o, elc_event_o;
  logic [5:0] addr_i;
  logic [15:0] wdata_i, rdata_o, v;
  logic [2:0] normal_o, counter_o;
  logic [3:0] match_irq_o;
  cnt_state_t state_o;
  int n_mismatch, checks_done, overlaps, convs, n_tog, n_und, n_ph, pos, dconv, n_elc;
  int hi_n[3], hi_c[3];
  int cmp[3] = '{3, 2, 4};
  // m=5 period, p=1 dead time; unmapped 0x3c must read 0 and drop writes
  row_t rows[11] = '{'{`OFS_CTRL, 0, 0, `CTRL_RST}, '{`OFS_PER, 0, 0, `PER_RST},
    '{`OFS_FUNC, 0, 0, `FUNC_RST}, '{`OFS_ADCC, 0, 0, `ADCC_RST},
    '{6'h3c, 1, 16'h1234, 16'h0000}, '{`OFS_PER, 1, 16'h0005, 16'h0005},
    '{`OFS_PH1, 1, 16'h0003, 16'h0003}, '{`OFS_PH2, 1, 16'h0002, 16'h0002},
    '{`OFS_PH3, 1, 16'h0004, 16'h0004}, '{`OFS_SEC, 1, 16'h0007, 16'h0007},
    '{`OFS_PRIM, 1, 16'h0001, 16'h0001}};

  cpwm_three_phase #(.WIDTH(16)) cpwm_three_phase_inst (.clk_i(clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .clk_pin_i(clk_pin_i), .cutoff_pin_i(cutoff_pin_i), .normal_o(normal_o),
    .counter_o(counter_o), .toggle_o(toggle_o), .match_irq_o(match_irq_o),
    .underflow_irq_o(underflow_irq_o), .adc_trig_o(adc_trig_o),
    .elc_event_o(elc_event_o), .state_o(state_o));
  gate_adc_model gate_adc_model_inst (.clk_i(clk_i), .normal_i(normal_o),
    .counter_i(counter_o), .adc_trig_i(adc_trig_o), .overlap_o(overlaps), .conv_o(convs));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask
  // one full period from just after a crest pulse; the next pulse must land on sample 12
  task automatic measure();
    int i;
    logic t;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
    end while (match_irq_o[0] !== 1'b1 && i < 60);
    {n_tog, n_und, n_ph, pos, n_elc} = '0;
    hi_n = '{0, 0, 0};
    hi_c = '{0, 0, 0};
    dconv = convs;
    t = toggle_o;
    for (int k = 1; k <= 12; k++) begin
      @(negedge clk_i);
      for (int j = 0; j < 3; j++) begin
        hi_n[j] += int'(normal_o[j]);
        hi_c[j] += int'(counter_o[j]);
      end
      if (match_irq_o[0] === 1'b1) pos = k;
      n_tog += int'(toggle_o !== t);
      t = toggle_o;
      n_und += int'(underflow_irq_o === 1'b1);
      n_elc += int'(elc_event_o === 1'b1);
      n_ph += int'(match_irq_o[3:1] != 3'h0);
    end
    dconv = convs - dconv;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_i);
    n_mismatch++;
    test_done();
  end
  initial begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i, clk_pin_i, cutoff_pin_i} = '0;
    rst_i = 1'b1;
    n_mismatch = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("state", {14'h0, state_o}, {14'h0, ST_STOP});
    foreach (rows[r]) begin
      if (rows[r].w) wr(rows[r].a, rows[r].d);
      rd(rows[r].a);
      check("read back", v, rows[r].e);
    end
    wr(`OFS_FUNC, 16'h0001);
    // both runs, stop select, active high levels, cutoff enabled
    wr(`OFS_CTRL, 16'h0167);
    measure();
    check("period", 16'(pos), 16'd12);
    check("toggles", 16'(n_tog), 16'd2);
    check("underflow", 16'(n_und), 16'd1);
    check("phase match", 16'(n_ph != 0), 16'd1);
    check("adc crest", 16'(dconv), 16'd1);
    check("ph1 normal", 16'(hi_n[0]), 16'(2 * (5 - cmp[0])));
    check("ph1 counter", 16'(hi_c[0]), 16'(2 * cmp[0]));
    check("ph2 normal", 16'(hi_n[1]), 16'(2 * (5 - cmp[1])));
    check("ph2 counter", 16'(hi_c[1]), 16'(2 * cmp[1]));
    check("ph3 normal", 16'(hi_n[2]), 16'(2 * (5 - cmp[2])));
    check("ph3 counter", 16'(hi_c[2]), 16'(2 * cmp[2]));
    rd(`OFS_PRIM);
    check("count range", 16'(v <= 16'h0005), 16'd1);
    // new period and underflow trigger while running
    wr(`OFS_PER, 16'h0009);
    wr(`OFS_FUNC, 16'h0003);
    measure();
    check("fixed period", 16'(pos), 16'd12);
    check("adc trough", 16'(dconv), 16'd1);
    wr(`OFS_ADCC, 16'h0007);
    measure();
    check("adc phase", 16'(dconv > 1), 16'd1);
    @(posedge clk_i);
    cutoff_pin_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    check("cut normal", {13'h0, normal_o}, 16'h0000);
    check("cut counter", {13'h0, counter_o}, 16'h0000);
    @(posedge clk_i);
    cutoff_pin_i <= 1'b0;
    wr(`OFS_STAT, 16'h0001);
    measure();
    check("resumed", 16'(hi_n[0]), 16'd4);
    check("overlap", 16'(overlaps), 16'd0);
    // external clock selected with the pin idle: counting must freeze
    wr(`OFS_CTRL, 16'h01e7);
    rd(`OFS_PRIM);
    dconv = int'(v);
    repeat (5) @(negedge clk_i);
    rd(`OFS_PRIM);
    check("ext clock hold", v, 16'(dconv));
    wr(`OFS_CTRL, 16'h0167);
    // crest trigger routed to the event link only
    wr(`OFS_FUNC, 16'h0005);
    wr(`OFS_ADCC, 16'h0000);
    measure();
    check("elc event", 16'(n_elc), 16'd1);
    check("elc no direct", 16'(dconv), 16'd0);
    wr(`OFS_CTRL, 16'h0164);
    repeat (2) @(negedge clk_i);
    check("stopped", {14'h0, state_o}, {14'h0, ST_STOP});
    check("stop normal", {13'h0, normal_o}, 16'h0000);
    wr(`OFS_CTRL, 16'h0018);
    repeat (2) @(negedge clk_i);
    check("init normal", {13'h0, normal_o}, 16'h0007);
    check("init counter", {13'h0, counter_o}, 16'h0007);
    @(posedge clk_i);
    clk_pin_i <= 1'b1;
    rd(`OFS_STAT);
    check("clock pin", v & 16'h0011, 16'h0010);
    test_done();
  end
endmodule // complementary_three_phase_pwm_bench
`default_nettype wire
